// ---- hw/pd_hold_logic.sv ----
// Sleep-pin hold sequencer, pin keepers and copy-protection fuse
`timescale 1ns/10ps
`default_nettype none
`include "pd_hold_map.svh"

module pd_hold_logic (
    input  wire logic                          clk_sys_i,
    input  wire logic                          sys_rst_i,
    input  wire logic                          shared_input_sleep_pin_i,
    input  wire logic                          sleep_pin_drv_i,
    input  wire logic [`PDH_N_IN-1:0]          in_pin_i,
    input  wire logic [`PDH_N_IN-1:0]          in_drv_i,
    input  wire logic [`PDH_N_IO-1:0]          io_pin_i,
    input  wire logic [`PDH_N_IO-1:0]          io_drv_i,
    output logic      [`PDH_N_IO-1:0]          io_out_o,
    output logic      [`PDH_N_IO-1:0]          io_oe_n_o,
    input  wire logic [`PDH_N_IO-1:0]          arr_reg_d_i,
    input  wire logic [`PDH_N_IO-1:0]          arr_comb_i,
    input  wire logic [`PDH_N_IO-1:0]          arr_sel_reg_i,
    input  wire logic [`PDH_N_IO-1:0]          arr_oe_i,
    output logic      [`PDH_N_IN-1:0]          arr_in_o,
    output logic      [`PDH_N_IO-1:0]          arr_io_o,
    output logic                               arr_sleep_in_o,
    output logic      [`PDH_N_IO-1:0]          arr_fb_o,
    output logic      [`PDH_N_IO-1:0]          reg_q_o,
    output logic      [`PDH_N_IO-1:0]          comb_q_o,
    output logic                               sleep_hold_o,
    input  wire logic                          prog_req_i,
    input  wire pd_hold_pkg::prog_op_t         prog_op_i,
    input  wire logic [`PDH_WD_W-1:0]          prog_wdata_i,
    output logic                               prog_ack_o,
    output logic                               prog_refused_o,
    output logic      [`PDH_WD_W-1:0]          prog_rdata_o
);
    import pd_hold_pkg::*;

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    mode_t                   mode_q;
    logic [`PDH_POR_W-1:0]   por_cnt_q;
    logic                    sleep_en_q;
    logic                    fuse_q;
    logic [`PDH_SIG_W-1:0]   sig_q;
    logic [`PDH_N_IO-1:0]    reg_q;
    logic [`PDH_N_IO-1:0]    comb_q;
    logic [`PDH_N_IO-1:0]    io_out_q;
    logic [`PDH_N_IO-1:0]    io_oe_n_q;
    logic                    sleep_in_q;
    logic                    ack_q;
    logic                    refused_q;
    logic [`PDH_WD_W-1:0]    rdata_q;
    logic                    hold_q;
    logic                    sleep_kept;
    logic                    sleep_active;
    logic                    freeze;
    logic                    taken;
    logic                    locked_op;
    logic [`PDH_IMG_W-1:0]   img_bits;

    // ------------------------------------------------------------
    // Pin keepers
    // ------------------------------------------------------------
    // Sleep pin is never blocked
    pin_keeper #(.W(1)) u_keep_sleep (
        .clk_sys_i (clk_sys_i),
        .sys_rst_i (sys_rst_i),
        .pin_i     (shared_input_sleep_pin_i),
        .ext_drv_i (sleep_pin_drv_i),
        .own_drv_i (1'b0),
        .own_val_i (1'b0),
        .hold_i    (1'b0),
        .kept_o    (sleep_kept)
    );

    // Dedicated inputs are frozen during hold
    pin_keeper #(.W(`PDH_N_IN)) u_keep_in (
        .clk_sys_i (clk_sys_i),
        .sys_rst_i (sys_rst_i),
        .pin_i     (in_pin_i),
        .ext_drv_i (in_drv_i),
        .own_drv_i ('0),
        .own_val_i ('0),
        .hold_i    (freeze),
        .kept_o    (arr_in_o)
    );

    // I/O pins see their own buffer while it drives
    pin_keeper #(.W(`PDH_N_IO)) u_keep_io (
        .clk_sys_i (clk_sys_i),
        .sys_rst_i (sys_rst_i),
        .pin_i     (io_pin_i),
        .ext_drv_i (io_drv_i),
        .own_drv_i (~io_oe_n_q),
        .own_val_i (io_out_q),
        .hold_i    (freeze),
        .kept_o    (arr_io_o)
    );

    // ------------------------------------------------------------
    // Hold sequencer
    // ------------------------------------------------------------
    // Sleep only counts when the configuration bit enables it
    assign sleep_active = sleep_en_q & sleep_kept;
    assign freeze       = (mode_q != MODE_RUN) | sleep_active;

    // Power-up interval, then run, hold on sleep, resume on release
    always_ff @(posedge clk_sys_i)
    begin
        if (sys_rst_i)
        begin
            mode_q    <= MODE_POR;
            por_cnt_q <= '0;
            hold_q    <= 1'b0;
        end
        else
        begin
            hold_q <= ((mode_q == MODE_RUN) || (mode_q == MODE_HOLD)) && sleep_active; // Next mode
            case (mode_q)
                MODE_POR:
                begin
                    if (por_cnt_q == `PDH_POR_W'(`PDH_POR_CYC - 1))
                        mode_q <= MODE_RUN;
                    por_cnt_q <= por_cnt_q + `PDH_POR_W'(1);
                end
                MODE_RUN:
                begin
                    if (sleep_active)
                        mode_q <= MODE_HOLD;
                end
                MODE_HOLD:
                begin
                    if (!sleep_active)
                        mode_q <= MODE_RUN;
                end
                default:
                    mode_q <= MODE_POR;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Macrocell outputs
    // ------------------------------------------------------------
    // Outputs update only while running; hold keeps all of them
    always_ff @(posedge clk_sys_i)
    begin
        if (sys_rst_i)
        begin
            reg_q     <= '0;
            comb_q    <= '0;
            io_out_q  <= '0;
            io_oe_n_q <= '1;
        end
        else if (taken && prog_op_i == OP_PRELOAD && !fuse_q)
            reg_q <= prog_wdata_i[`PDH_N_IO-1:0];
        else if (!freeze)
        begin
            reg_q     <= arr_reg_d_i;
            comb_q    <= arr_comb_i;
            io_out_q  <= (arr_sel_reg_i & arr_reg_d_i) | (~arr_sel_reg_i & arr_comb_i);
            io_oe_n_q <= ~arr_oe_i;
        end
    end

    // Shared pin array input is dropped while it serves as sleep pin
    always_ff @(posedge clk_sys_i)
    begin
        if (sys_rst_i)
            sleep_in_q <= 1'b0;
        else if (sleep_en_q)
            sleep_in_q <= 1'b0;
        else
            sleep_in_q <= sleep_kept;
    end

    // ------------------------------------------------------------
    // Programming agent port
    // ------------------------------------------------------------
    assign taken     = prog_req_i & ~freeze;
    assign locked_op = fuse_q & ((prog_op_i == OP_VERIFY) | (prog_op_i == OP_PRELOAD));
    assign img_bits  = sleep_en_q ? `PDH_IMG_SLEEP : `PDH_IMG_PLAIN;

    // Configuration store: signature, sleep bit, fuse
    always_ff @(posedge clk_sys_i)
    begin
        if (sys_rst_i)
        begin
            sig_q      <= '0;
            sleep_en_q <= 1'b0;
            fuse_q     <= 1'b0;
        end
        else if (taken)
        begin
            case (prog_op_i)
                OP_WRITE_SIG: sig_q      <= prog_wdata_i;
                OP_WRITE_CFG: sleep_en_q <= prog_wdata_i[`PDH_CFG_SLP_BIT];
                OP_SET_FUSE:  fuse_q     <= 1'b1;
                default:      sig_q      <= sig_q;
            endcase
        end
    end

    // One-cycle answer after each taken request
    always_ff @(posedge clk_sys_i)
    begin
        if (sys_rst_i)
        begin
            ack_q     <= 1'b0;
            refused_q <= 1'b0;
            rdata_q   <= '0;
        end
        else
        begin
            ack_q     <= taken & ~locked_op;
            refused_q <= taken & locked_op;
            if (taken && prog_op_i == OP_READ_SIG)
                rdata_q <= sig_q;
            else if (taken && prog_op_i == OP_VERIFY && !fuse_q)
            begin
                rdata_q <= '0;
                rdata_q[`PDH_RD_IMG_LSB +: `PDH_IMG_W] <= img_bits;
                rdata_q[`PDH_RD_SLP_BIT] <= sleep_en_q;
            end
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign io_out_o       = io_out_q;
    assign io_oe_n_o      = io_oe_n_q;
    assign reg_q_o        = reg_q;
    assign comb_q_o       = comb_q;
    assign arr_fb_o       = reg_q;
    assign arr_sleep_in_o = sleep_in_q;
    assign sleep_hold_o   = hold_q;
    assign prog_ack_o     = ack_q;
    assign prog_refused_o = refused_q;
    assign prog_rdata_o   = rdata_q;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (sys_rst_i);

    sequence s_two_hold;
        (mode_q == MODE_HOLD) ##1 (mode_q == MODE_HOLD);
    endsequence

    property p_enter_hold;
        (mode_q == MODE_RUN) && sleep_en_q && sleep_kept |=> (mode_q == MODE_HOLD);
    endproperty
    a_enter_hold: assert property (p_enter_hold) else $error("sleep did not enter hold");

    property p_hold_keep;
        s_two_hold |-> $stable(reg_q_o) && $stable(comb_q_o);
    endproperty
    a_hold_keep: assert property (p_hold_keep) else $error("outputs moved in hold");

    property p_hold_io;
        s_two_hold |-> $stable(io_out_o) && $stable(io_oe_n_o);
    endproperty
    a_hold_io: assert property (p_hold_io) else $error("io changed in hold");

    property p_hold_inputs;
        s_two_hold |-> $stable(arr_in_o) && $stable(arr_io_o);
    endproperty
    a_hold_inputs: assert property (p_hold_inputs) else $error("input passed in hold");

    property p_sleep_input;
        $past(sleep_en_q) |-> !arr_sleep_in_o;
    endproperty
    a_sleep_input: assert property (p_sleep_input) else $error("sleep pin reached array");

    property p_plain_input;
        !sleep_en_q |=> (arr_sleep_in_o == $past(sleep_kept));
    endproperty
    a_plain_input: assert property (p_plain_input) else $error("plain input wrong");

    property p_refuse;
        taken && fuse_q && (prog_op_i == OP_VERIFY || prog_op_i == OP_PRELOAD)
            |=> prog_refused_o && !prog_ack_o && (reg_q_o == $past(arr_reg_d_i));
    endproperty
    a_refuse: assert property (p_refuse) else $error("locked op not refused");

    property p_sig_read;
        taken && (prog_op_i == OP_READ_SIG) |=> prog_ack_o && (prog_rdata_o == $past(sig_q));
    endproperty
    a_sig_read: assert property (p_sig_read) else $error("signature read failed");

    property p_fuse_now;
        taken && (prog_op_i == OP_SET_FUSE) ##1 taken && (prog_op_i == OP_VERIFY)
            |=> prog_refused_o;
    endproperty
    a_fuse_now: assert property (p_fuse_now) else $error("fuse not immediate");

    property p_por_clear;
        $past(sys_rst_i) |-> (reg_q_o == '0) && (mode_q == MODE_POR) && !prog_ack_o;
    endproperty
    a_por_clear: assert property (p_por_clear) else $error("reset did not clear");

    property p_resume;
        (mode_q == MODE_HOLD) && !sleep_active |=> (mode_q == MODE_RUN) ##1
            ($past(sleep_active) || $past(taken) || (reg_q_o == $past(arr_reg_d_i)));
    endproperty
    a_resume: assert property (p_resume) else $error("no resume after sleep");

    property p_por_len;
        (mode_q == MODE_POR) && (por_cnt_q == '0) |-> (mode_q == MODE_POR) [*8];
    endproperty
    a_por_len: assert property (p_por_len) else $error("power-up interval short");

    c_hold: cover property ((mode_q == MODE_RUN) ##1 (mode_q == MODE_HOLD));
    c_wake: cover property ((mode_q == MODE_HOLD) ##1 (mode_q == MODE_RUN));
    c_refused: cover property (prog_refused_o);
    c_preload: cover property (taken && prog_op_i == OP_PRELOAD && !fuse_q);

endmodule

`default_nettype wire

// ---- hw/pd_hold_map.svh ----
// Constants for the sleep-pin hold and copy-protection block
`ifndef PD_HOLD_MAP_SVH
`define PD_HOLD_MAP_SVH

// Pin counts and data widths
`define PDH_N_IN        10
`define PDH_N_IO        10
`define PDH_SIG_W       64
`define PDH_WD_W        64

// Configuration image sizes (5893 with sleep bit, 5892 without)
`define PDH_IMG_W       13
`define PDH_IMG_SLEEP   13'h1705
`define PDH_IMG_PLAIN   13'h1704

// Read-data and config write-data field positions
`define PDH_RD_IMG_LSB  0
`define PDH_RD_SLP_BIT  16
`define PDH_CFG_SLP_BIT 0

// Power-up reset interval, longest time rounded down
`define PDH_T_PR_NS     1000
`define PDH_CLK_NS      10
`define PDH_POR_W       7
`define PDH_POR_CYC     (`PDH_T_PR_NS / `PDH_CLK_NS)

`endif

// ---- hw/pd_hold_pkg.sv ----
// Types shared by the sleep-pin hold block
package pd_hold_pkg;

    // Operating modes of the hold sequencer
    typedef enum logic [1:0] {
        MODE_POR,
        MODE_RUN,
        MODE_HOLD
    } mode_t;

    // Programming agent operations
    typedef enum logic [2:0] {
        OP_WRITE_SIG,
        OP_READ_SIG,
        OP_WRITE_CFG,
        OP_SET_FUSE,
        OP_VERIFY,
        OP_PRELOAD
    } prog_op_t;

endpackage

// ---- hw/pin_keeper.sv ----
// Synchronised pin keeper with hold latch
`timescale 1ns/10ps
`default_nettype none

module pin_keeper #(
    parameter int W = 1
) (
    input  wire logic         clk_sys_i,
    input  wire logic         sys_rst_i,
    input  wire logic [W-1:0] pin_i,
    input  wire logic [W-1:0] ext_drv_i,
    input  wire logic [W-1:0] own_drv_i,
    input  wire logic [W-1:0] own_val_i,
    input  wire logic         hold_i,
    output logic      [W-1:0] kept_o
);

    logic [W-1:0] pin_s1_q;
    logic [W-1:0] pin_s2_q;
    logic [W-1:0] drv_s1_q;
    logic [W-1:0] drv_s2_q;
    logic [W-1:0] kept_q;
    logic [W-1:0] kept_d;

    // Two-stage synchroniser for pin level and external drive
    always_ff @(posedge clk_sys_i)
    begin
        if (sys_rst_i)
        begin
            pin_s1_q <= '0;
            pin_s2_q <= '0;
            drv_s1_q <= '0;
            drv_s2_q <= '0;
        end
        else
        begin
            pin_s1_q <= pin_i;
            pin_s2_q <= pin_s1_q;
            drv_s1_q <= ext_drv_i;
            drv_s2_q <= drv_s1_q;
        end
    end

    // Own buffer wins, then outside driver, else keep last level
    assign kept_d = (own_drv_i & own_val_i)
                  | (~own_drv_i & drv_s2_q & pin_s2_q)
                  | (~own_drv_i & ~drv_s2_q & kept_q);

    // Latch stays closed but valid while holding
    always_ff @(posedge clk_sys_i)
    begin
        if (sys_rst_i)
            kept_q <= '0;
        else if (!hold_i)
            kept_q <= kept_d;
        else
            kept_q <= kept_q;
    end

    assign kept_o = kept_q;

endmodule

`default_nettype wire

// ---- tb/board_model.sv ----
// Board-side model driving the shared sleep pin, the inputs and the I/O pins
`timescale 1ns/10ps
`default_nettype none
`include "pd_hold_map.svh"

module board_model (
    input  wire logic                 clk_sys_i,
    input  wire logic                 sleep_val_i,
    input  wire logic                 sleep_en_i,
    input  wire logic [`PDH_N_IN-1:0] in_val_i,
    input  wire logic [`PDH_N_IN-1:0] in_en_i,
    input  wire logic [`PDH_N_IO-1:0] io_val_i,
    input  wire logic [`PDH_N_IO-1:0] io_en_i,
    input  wire logic [`PDH_N_IO-1:0] io_out_i,
    input  wire logic [`PDH_N_IO-1:0] io_oe_n_i,
    output logic                      sleep_pin_o,
    output logic      [`PDH_N_IN-1:0] in_pin_o,
    output logic      [`PDH_N_IO-1:0] io_pin_o
);
    logic                 sleep_last_q = 1'b0;
    logic [`PDH_N_IN-1:0] in_last_q    = '0;
    logic [`PDH_N_IO-1:0] io_last_q    = '0;
    logic [`PDH_N_IO-1:0] io_ext;

    // Remember the last level the board drove on each pin
    always @(posedge clk_sys_i)
    begin
        if (sleep_en_i)
            sleep_last_q <= sleep_val_i;
        in_last_q <= (in_en_i & in_val_i) | (~in_en_i & in_last_q);
        io_last_q <= (io_en_i & io_val_i) | (~io_en_i & io_last_q);
    end

    // A released pin shows the inverse of its last level, so only a keeper can hold it
    assign sleep_pin_o = sleep_en_i ? sleep_val_i : ~sleep_last_q;
    assign in_pin_o    = (in_en_i & in_val_i) | (~in_en_i & ~in_last_q);
    assign io_ext      = (io_en_i & io_val_i) | (~io_en_i & ~io_last_q);
    // The device's own driver wins where its enable is low
    assign io_pin_o    = (~io_oe_n_i & io_out_i) | (io_oe_n_i & io_ext);
endmodule
`default_nettype wire

// ---- tb/tb_pin_power_down_hold_logic.sv ----
// Self-checking testbench for the sleep-pin hold and protection fuse block
`timescale 1ns/10ps
`default_nettype none
`include "pd_hold_map.svh"

module tb_pin_power_down_hold_logic;
    import pd_hold_pkg::*;
    localparam logic [9:0] A_REG = 10'h1C6, A_CMB = 10'h239, A_SEL = 10'h0F0, A_OE = 10'h3C0;
    localparam logic [9:0] B_REG = 10'h2B4, B_CMB = 10'h0CF, B_SEL = 10'h3F0, B_OE = 10'h30F;
    localparam logic [63:0] SIG = 64'hC3A5_0F1E_7D29_B486;

    logic       clk_sys_i = 1'b0;
    logic       sys_rst_i = 1'b1;
    logic       sleep_val = 1'b0, sleep_en = 1'b1, sleep_pin;
    logic [9:0] in_val = '0, in_en = '0, io_val = '0, io_en = '0, in_pin, io_pin;
    logic [9:0] reg_d = '0, cmb = '0, sel = '0, oe = '0;
    logic [9:0] io_out, io_oe_n, arr_in, arr_io, arr_fb, reg_q, comb_q;
    logic       arr_sleep_in, sleep_hold, ack, refused, prog_req = 1'b0;
    logic [63:0] wdata = '0, rdata;
    prog_op_t   prog_op = OP_READ_SIG;
    int         failures = 0, total_checks = 0;

    always #5 clk_sys_i = ~clk_sys_i;

    board_model u_board_model (.clk_sys_i(clk_sys_i), .sleep_val_i(sleep_val),
        .sleep_en_i(sleep_en), .in_val_i(in_val), .in_en_i(in_en), .io_val_i(io_val),
        .io_en_i(io_en), .io_out_i(io_out), .io_oe_n_i(io_oe_n), .sleep_pin_o(sleep_pin),
        .in_pin_o(in_pin), .io_pin_o(io_pin));

    pd_hold_logic u_pd_hold_logic (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i),
        .shared_input_sleep_pin_i(sleep_pin), .sleep_pin_drv_i(sleep_en),
        .in_pin_i(in_pin), .in_drv_i(in_en), .io_pin_i(io_pin), .io_drv_i(io_en),
        .io_out_o(io_out), .io_oe_n_o(io_oe_n), .arr_reg_d_i(reg_d), .arr_comb_i(cmb),
        .arr_sel_reg_i(sel), .arr_oe_i(oe), .arr_in_o(arr_in), .arr_io_o(arr_io),
        .arr_sleep_in_o(arr_sleep_in), .arr_fb_o(arr_fb), .reg_q_o(reg_q),
        .comb_q_o(comb_q), .sleep_hold_o(sleep_hold), .prog_req_i(prog_req),
        .prog_op_i(prog_op), .prog_wdata_i(wdata), .prog_ack_o(ack),
        .prog_refused_o(refused), .prog_rdata_o(rdata));

    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            failures++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic print_verdict();
        $display("checks=%0d failures=%0d", total_checks, failures);
        if (failures == 0 && total_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // Request stays up so requests can follow back to back
    task automatic prog(input prog_op_t op, input logic [63:0] wd);
        prog_req = 1'b1;
        prog_op  = op;
        wdata    = wd;
        @(negedge clk_sys_i);
    endtask

    task automatic idle();
        prog_req = 1'b0;
        @(negedge clk_sys_i);
    endtask

    task automatic set_arr(input logic [9:0] r, c, s, o);
        reg_d = r;
        cmb   = c;
        sel   = s;
        oe    = o;
    endtask

    task automatic wait_hold(input logic v);
        for (int i = 0; i < 20; i++)
        begin
            @(negedge clk_sys_i);
            if (sleep_hold === v)
                return;
        end
        failures++;
        print_verdict();
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic test_array();
        set_arr(B_REG, B_CMB, B_SEL, B_OE);
        @(negedge clk_sys_i);
        check(reg_q, B_REG);
        check(comb_q, B_CMB);
        check(io_out, (B_SEL & B_REG) | (~B_SEL & B_CMB));
        check(io_oe_n, 10'(~B_OE));
        check(arr_fb, B_REG);
        prog(OP_PRELOAD, 64'h155);
        check(ack, 1'b1);
        check(reg_q, 10'h155);
        idle();
        $display("test array done");
    endtask

    task automatic test_keeper();
        in_val = 10'h2A5;
        in_en  = '1;
        io_val = 10'h15A;
        io_en  = '1;
        set_arr(B_REG, 10'h3C3, 10'h000, 10'h000);
        repeat (5) @(negedge clk_sys_i);
        check(arr_in, 10'h2A5);
        check(arr_io, 10'h15A);
        in_en = '0;
        io_en = '0;
        repeat (5) @(negedge clk_sys_i);
        check(arr_in, 10'h2A5);
        check(arr_io, 10'h15A);
        oe = '1;
        repeat (5) @(negedge clk_sys_i);
        check(arr_io, 10'h3C3);
        $display("test keeper done");
    endtask

    task automatic test_plain();
        prog(OP_VERIFY, 64'h0);
        check(rdata[16:0], {1'b0, 3'h0, `PDH_IMG_PLAIN});
        idle();
        sleep_val = 1'b1;
        repeat (6) @(negedge clk_sys_i);
        check(arr_sleep_in, 1'b1);
        check(sleep_hold, 1'b0);
        sleep_val = 1'b0;
        repeat (6) @(negedge clk_sys_i);
        $display("test plain done");
    endtask

    task automatic test_hold();
        prog(OP_WRITE_CFG, 64'h1);
        prog(OP_VERIFY, 64'h0);
        check(rdata[16:0], {1'b1, 3'h0, `PDH_IMG_SLEEP});
        idle();
        in_val = 10'h0F0;
        in_en  = '1;
        set_arr(A_REG, A_CMB, A_SEL, A_OE);
        repeat (5) @(negedge clk_sys_i);
        sleep_val = 1'b1;
        wait_hold(1'b1);
        check(arr_sleep_in, 1'b0);
        set_arr(B_REG, B_CMB, B_SEL, B_OE);
        in_val = 10'h30C;
        prog(OP_READ_SIG, 64'h0);
        idle();
        check(ack, 1'b0);
        in_en = '0;
        sleep_en = 1'b0; // Released sleep pin must be kept high
        repeat (5) @(negedge clk_sys_i);
        check(sleep_hold, 1'b1);
        check(reg_q, A_REG);
        check(comb_q, A_CMB);
        check(io_out, (A_SEL & A_REG) | (~A_SEL & A_CMB));
        check(io_oe_n, 10'(~A_OE));
        check(arr_in, 10'h0F0);
        in_en = '1;
        sleep_en = 1'b1;
        sleep_val = 1'b0;
        wait_hold(1'b0);
        // Outputs load on the edge after hold mode ends
        @(negedge clk_sys_i);
        check(reg_q, B_REG);
        check(io_oe_n, 10'(~B_OE));
        repeat (5) @(negedge clk_sys_i);
        check(arr_in, 10'h30C);
        $display("test hold done");
    endtask

    task automatic test_fuse();
        prog(OP_WRITE_SIG, SIG);
        check(ack, 1'b1);
        prog(OP_SET_FUSE, 64'h0);
        check(ack, 1'b1);
        prog(OP_VERIFY, 64'h0);
        check(refused, 1'b1);
        check(ack, 1'b0);
        prog(OP_PRELOAD, 64'h0AA);
        check(refused, 1'b1);
        check(reg_q, B_REG);
        prog(OP_READ_SIG, 64'h0);
        check(ack, 1'b1);
        check(rdata, SIG);
        idle();
        $display("test fuse done");
    endtask

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial
    begin
        repeat (20) @(negedge clk_sys_i);
        check(reg_q, 10'h000);
        check(io_oe_n, 10'h3FF);
        sys_rst_i = 1'b0;
        repeat (102) @(negedge clk_sys_i);
        $display("test reset done");
        test_array();
        test_keeper();
        test_plain();
        test_hold();
        test_fuse();
        print_verdict();
    end
endmodule
`default_nettype wire
